// ===== rtl/stes_top.sv
// stimulus train event sequencer with a wishbone register slave
//
// Our own choices: the register addresses and the Wishbone register port.
`default_nettype none
module stes_top #(
    parameter int unsigned KEY_HOLD_CYC = stes_pkg::KEY_HOLD_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output var logic [31:0] wb_dat_o,
    output var logic wb_ack_o,
    // pins
    input wire logic start_stimulus_input_i,
    input wire logic gate_i,
    input wire logic general_screen_key_i,
    // stimulus outputs
    output var logic signed [15:0] amplitude_o,
    output var logic output_connected_o,
    output var logic timing_marker_out_a_o
);
    import stes_pkg::*;

    function automatic logic [31:0] m1(input logic [31:0] x);
        m1 = (x == 32'h0) ? 32'h0 : x - 32'h1;
    endfunction

    function automatic logic signed [15:0] sat_add(
        input logic signed [15:0] a,
        input logic signed [15:0] b
    );
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s[16] != s[15]) begin
            sat_add = s[16] ? 16'sh8000 : 16'sh7fff;
        end else begin
            sat_add = s[15:0];
        end
    endfunction

    // input synchronisers: three stages, level moves once stages 2 and 3 agree
    logic [2:0] trg_s_q;
    logic [2:0] gat_s_q;
    logic [2:0] key_s_q;
    logic trg_lvl_q;
    logic gate_lvl_q;
    logic key_lvl_q;
    logic trg_prev_q;

    always_ff @(posedge clk_i) begin
        trg_s_q <= {trg_s_q[1:0], start_stimulus_input_i};
        gat_s_q <= {gat_s_q[1:0], gate_i};
        key_s_q <= {key_s_q[1:0], general_screen_key_i};
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            trg_lvl_q <= 1'b0;
            gate_lvl_q <= 1'b0;
            key_lvl_q <= 1'b0;
            trg_prev_q <= 1'b0;
        end else begin
            if (trg_s_q[1] == trg_s_q[2]) trg_lvl_q <= trg_s_q[2];
            if (gat_s_q[1] == gat_s_q[2]) gate_lvl_q <= gat_s_q[2];
            if (key_s_q[1] == key_s_q[2]) key_lvl_q <= key_s_q[2];
            trg_prev_q <= trg_lvl_q;
        end
    end

    // register bank
    logic [31:0] cfg_q [NREG_RW];
    logic ack_q;
    logic [31:0] dat_q;
    logic [3:0] idx;
    logic mapped;
    logic wr_en;
    logic [31:0] rd_word;
    logic [31:0] stat_word;
    logic load_def;

    assign idx = wb_adr_i[5:2];
    assign mapped = (wb_adr_i[7:6] == 2'b00) && (idx <= IDX_STAT);
    // a write lands on the edge where the master sees ack high
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && mapped;

    genvar gi;
    generate
        for (gi = 0; gi < NREG_RW; gi++) begin : g_reg
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    cfg_q[gi] <= RST_VAL[gi];
                end else if (load_def) begin
                    cfg_q[gi] <= DEF_VAL[gi];
                end else if (wr_en && idx == 4'(gi)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            cfg_q[gi][8*b +: 8] <= wb_dat_i[8*b +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    // control fields
    logic free_run;
    logic trail_edge;
    logic hold_mode;
    logic out_en;
    logic mark_evt;
    logic [15:0] tcnt;
    logic [15:0] eqty;
    logic signed [15:0] level;
    logic signed [15:0] ampl;
    logic [31:0] tdly_eff;

    assign free_run = cfg_q[IDX_CTRL][CB_FREE];
    assign trail_edge = cfg_q[IDX_CTRL][CB_TRAIL];
    assign hold_mode = cfg_q[IDX_CTRL][CB_HOLD];
    assign out_en = cfg_q[IDX_CTRL][CB_OEN];
    assign mark_evt = cfg_q[IDX_CTRL][CB_MEVT];
    assign tcnt = cfg_q[IDX_TCNT][15:0];
    assign eqty = cfg_q[IDX_EQTY][15:0];
    assign level = cfg_q[IDX_LEVEL][15:0];
    assign ampl = cfg_q[IDX_AMPL][15:0];
    // short programmed delays are stretched to the minimum onset
    assign tdly_eff = (cfg_q[IDX_TDLY] < 32'(MIN_ONSET_CYC)) ?
        32'(MIN_ONSET_CYC) : cfg_q[IDX_TDLY];

    // power-up key timer: only a press that starts right after reset counts
    logic boot_q;
    logic [31:0] key_cnt_q;
    logic def_done_q;

    assign load_def = boot_q && key_lvl_q &&
        (key_cnt_q == KEY_HOLD_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            boot_q <= 1'b1;
            key_cnt_q <= 32'h0;
            def_done_q <= 1'b0;
        end else if (boot_q) begin
            // the synchronised level reads low until the pin has come through
            if ((!key_lvl_q && key_cnt_q >= 32'(KEY_SETTLE_CYC)) ||
                load_def) begin
                boot_q <= 1'b0;
            end
            key_cnt_q <= key_cnt_q + 32'h1;
            if (load_def) def_done_q <= 1'b1;
        end
    end

    // train sequencer
    stes_state_type st_q;
    logic [31:0] cnt_q;
    logic [31:0] win_q;
    logic [31:0] per_q;
    logic [15:0] tn_q;
    logic trg_edge;
    logic trig_acc;
    logic win_open;
    logic win_close;

    assign trg_edge = trail_edge ? (trg_prev_q && !trg_lvl_q)
                                 : (!trg_prev_q && trg_lvl_q);
    // only the idle state listens, so triggers during a train are dropped
    assign trig_acc = (st_q == ST_IDLE) && gate_lvl_q &&
        (free_run || trg_edge);
    assign win_open = gate_lvl_q &&
        (((st_q == ST_DELAY) && (cnt_q == 32'h0)) ||
         ((st_q == ST_GAP) && (per_q == 32'h0)));
    assign win_close = (st_q == ST_WIN) &&
        ((win_q == 32'h0) || !gate_lvl_q);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= ST_IDLE;
            cnt_q <= 32'h0;
            win_q <= 32'h0;
            per_q <= 32'h0;
            tn_q <= 16'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (trig_acc) begin
                        cnt_q <= m1(tdly_eff);
                        st_q <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (!gate_lvl_q) begin
                        st_q <= ST_IDLE;
                    end else if (win_open) begin
                        win_q <= m1(cfg_q[IDX_TWIN]);
                        per_q <= m1(cfg_q[IDX_TPER]);
                        tn_q <= 16'(m1(32'(tcnt)));
                        st_q <= ST_WIN;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_WIN: begin
                    if (per_q != 32'h0) per_q <= per_q - 32'h1;
                    if (!gate_lvl_q) begin
                        st_q <= ST_IDLE;
                    end else if (win_close) begin
                        // last train done: back to accepting triggers
                        st_q <= (tn_q == 16'h0) ? ST_IDLE
                                                : ST_GAP;
                    end else begin
                        win_q <= win_q - 32'h1;
                    end
                end
                ST_GAP: begin
                    if (!gate_lvl_q) begin
                        st_q <= ST_IDLE;
                    end else if (win_open) begin
                        win_q <= m1(cfg_q[IDX_TWIN]);
                        per_q <= m1(cfg_q[IDX_TPER]);
                        tn_q <= tn_q - 16'h1;
                        st_q <= ST_WIN;
                    end else begin
                        per_q <= per_q - 32'h1;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // event engine, restarted at every window opening
    logic [31:0] ed_q;
    logic [31:0] ew_q;
    logic [31:0] ep_q;
    logic [15:0] en_q;
    logic ev_on_q;
    logic ev_start;

    assign ev_start = (st_q == ST_WIN) && !win_close &&
        (ed_q == 32'h0) && (ep_q == 32'h0) && (en_q != 16'h0);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ed_q <= 32'h0;
            ew_q <= 32'h0;
            ep_q <= 32'h0;
            en_q <= 16'h0;
            ev_on_q <= 1'b0;
        end else if (win_open) begin
            ed_q <= cfg_q[IDX_EDLY];
            en_q <= eqty;
            ep_q <= 32'h0;
            ev_on_q <= 1'b0;
        end else if (st_q != ST_WIN || win_close) begin
            // nothing may spill past the window edge
            en_q <= 16'h0;
            ev_on_q <= 1'b0;
        end else if (ed_q != 32'h0) begin
            ed_q <= ed_q - 32'h1;
        end else begin
            if (ep_q != 32'h0) ep_q <= ep_q - 32'h1;
            if (ev_on_q) begin
                if (ew_q == 32'h0) ev_on_q <= 1'b0;
                else ew_q <= ew_q - 32'h1;
            end
            if (ev_start) begin
                ev_on_q <= (cfg_q[IDX_EWID] != 32'h0);
                ew_q <= m1(cfg_q[IDX_EWID]);
                ep_q <= m1(cfg_q[IDX_EPER]);
                en_q <= en_q - 16'h1;
            end
        end
    end

    // output level
    logic signed [15:0] amp_d;
    logic signed [15:0] amp_q;
    logic mark_d;
    logic mark_q;
    logic conn_q;
    logic timing_on;

    assign timing_on = (st_q != ST_IDLE) && gate_lvl_q;
    // hold stays on whenever powered; offset only rides on live timing
    assign amp_d = hold_mode ?
        (ev_on_q ? ampl : level) :
        (!timing_on ? 16'sh0000 :
         ev_on_q ? sat_add(ampl, level) : level);
    assign mark_d = mark_evt ? ev_on_q
                             : (st_q == ST_WIN);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            amp_q <= 16'sh0000;
            mark_q <= 1'b0;
            conn_q <= 1'b0;
        end else begin
            amp_q <= amp_d;
            mark_q <= mark_d;
            conn_q <= out_en;
        end
    end

    // bus answer: ack one cycle after the request, read data with it
    assign stat_word = {tn_q, 11'h0, def_done_q, gate_lvl_q,
        ev_on_q, st_q == ST_WIN, st_q != ST_IDLE};
    assign rd_word = !mapped ? 32'h0 :
        (idx == IDX_STAT) ? stat_word : cfg_q[idx];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) dat_q <= rd_word;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign amplitude_o = amp_q;
    assign timing_marker_out_a_o = mark_q;
    assign output_connected_o = conn_q;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic [31:0] dly_seen_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || st_q != ST_DELAY) dly_seen_q <= 32'h0;
        else dly_seen_q <= dly_seen_q + 32'h1;
    end

    sequence s_last_close;
        st_q == ST_WIN && win_q == 32'h0 && tn_q == 16'h0 && gate_lvl_q;
    endsequence

    sequence s_onset;
        st_q == ST_DELAY ##1 st_q == ST_WIN;
    endsequence

    chk_min_onset: assert property (
        s_onset |-> dly_seen_q >= MIN_ONSET_CYC - 1)
        else $error("onset came before the minimum delay");
    chk_retrigger_block: assert property (
        st_q == ST_WIN |=> st_q != ST_DELAY)
        else $error("train restarted during a sequence");
    chk_gate_abort: assert property (
        !gate_lvl_q && st_q != ST_IDLE |=> st_q == ST_IDLE && !ev_on_q)
        else $error("gate low did not stop the train");
    chk_event_window: assert property (
        ev_on_q |-> st_q == ST_WIN)
        else $error("event outside train window");
    chk_free_run: assert property (
        free_run && gate_lvl_q && st_q == ST_IDLE |=> st_q == ST_DELAY)
        else $error("free run did not trigger");
    chk_edge_start: assert property (
        st_q == ST_IDLE && gate_lvl_q && trail_edge && !free_run &&
        trg_prev_q && !trg_lvl_q |=> st_q == ST_DELAY)
        else $error("trailing edge not accepted");
    chk_count_done: assert property (
        s_last_close |=> st_q == ST_IDLE ##1 !ev_on_q)
        else $error("sequence did not end after the last train");
    chk_hold_level: assert property (
        hold_mode && !ev_on_q && $stable(level) |=> amp_q == $past(level))
        else $error("hold level not driven");
    chk_marker_span: assert property (
        !mark_evt && $rose(st_q == ST_WIN) |=> mark_q)
        else $error("train marker missing");
    chk_event_width: assert property (
        ev_start && cfg_q[IDX_EWID] == 32'h2 && win_q > 32'h3 &&
        gate_lvl_q |=> ev_on_q [*2] ##1 !ev_on_q || ev_start)
        else $error("event width wrong");
endmodule // stes_top
`default_nettype wire

// ===== rtl/stes_pkg.sv
// constants and types for the stimulus train event sequencer
// Operation
// - one train delay after each accepted trigger, before the first train
// - train window opens when the delay ends; events only inside it
// - train window starts are spaced by the train repeat interval
// - exactly the programmed train count per accepted trigger; a train count of 0 still runs one train
// - event timing starts in the cycle the train window opens
// - the whole event list completes within one train window
// - one pre-event wait per train, none between later events
// - each event stays active for the programmed event width
// - event starts are spaced by the event repeat interval
// - events per train follow the event quantity setting
// - free-run makes internal triggers without waiting for the input
// - external trigger starts timing on its leading or trailing edge
// - triggers arriving during an active sequence are ignored
// - gate low blocks triggers; output goes to hold level or zero
// - gate low during a train stops output for that train
// - after the last train, timing stops and new triggers are taken
// - hold mode drives the hold level except during events
// - offset mode adds offset to amplitudes only while timing is active
// - trigger to stimulus onset is never below the minimum delay
// - marker shows event span or train window span as selected
// - key held five seconds after power-up loads the preset definition
// - output enable off only disconnects the path; timing keeps running
`default_nettype none
package stes_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned MIN_ONSET_NS = 2000;
    localparam int unsigned MIN_ONSET_CYC =
        (MIN_ONSET_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned KEY_HOLD_MS = 5000;
    localparam int unsigned KEY_HOLD_CYC = KEY_HOLD_MS * CLK_MHZ * 1000;
    // edges the key level needs to pass the synchroniser after reset
    localparam int unsigned KEY_SETTLE_CYC = 4;
    localparam int unsigned NREG = 12;
    localparam int unsigned NREG_RW = 11;
    // word indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_TDLY = 4'h1;
    localparam logic [3:0] IDX_TWIN = 4'h2;
    localparam logic [3:0] IDX_TPER = 4'h3;
    localparam logic [3:0] IDX_TCNT = 4'h4;
    localparam logic [3:0] IDX_EDLY = 4'h5;
    localparam logic [3:0] IDX_EWID = 4'h6;
    localparam logic [3:0] IDX_EPER = 4'h7;
    localparam logic [3:0] IDX_EQTY = 4'h8;
    localparam logic [3:0] IDX_LEVEL = 4'h9;
    localparam logic [3:0] IDX_AMPL = 4'ha;
    localparam logic [3:0] IDX_STAT = 4'hb;
    // control bits
    localparam int unsigned CB_FREE = 0;
    localparam int unsigned CB_TRAIL = 1;
    localparam int unsigned CB_HOLD = 2;
    localparam int unsigned CB_OEN = 3;
    localparam int unsigned CB_MEVT = 4;
    typedef logic [31:0] stes_word_type;
    typedef stes_word_type stes_bank_type [NREG_RW];
    localparam stes_bank_type RST_VAL = '{
        32'h0000_0000, 32'h0000_00c8, 32'h0000_0064, 32'h0000_00c8,
        32'h0000_0001, 32'h0000_0000, 32'h0000_000a, 32'h0000_0014,
        32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
    // preset: 2 trains of 2.5 ms every 3 ms, 2 events 200 us every 500 us
    localparam stes_bank_type DEF_VAL = '{
        32'h0000_0008, 32'h0000_00c8, 32'h0003_d090, 32'h0004_93e0,
        32'h0000_0002, 32'h0000_0000, 32'h0000_4e20, 32'h0000_c350,
        32'h0000_0002, 32'h0000_0000, 32'h0000_1388};
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_WIN = 4'b0100,
        ST_GAP = 4'b1000
    } stes_state_type;
endpackage
`default_nettype wire

// ===== tb/stes_src.sv
// behavioural source of the external trigger and gate pins
`default_nettype none
module stes_src #(
    parameter int PW = 20
) (
    // control from the bench
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic gate_en_i,
    // pins towards the sequencer
    output var logic trig_o = 1'b0,
    output var logic gate_o = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // a clean ttl level pulse of PW cycles, idle low; a pin is always driven
    always @(posedge clk_i) begin
        gate_o <= gate_en_i;
        if (fire_i && cnt == 0) begin
            cnt <= PW;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
        trig_o <= (cnt != 0);
    end
endmodule // stes_src
`default_nettype wire

// ===== tb/stes_top_bench.sv
// self-checking bench for the stimulus train event sequencer
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    n_fail++; $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module stes_top_bench import stes_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 20;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
    logic wb_ack_o, trig, gate, key = 1'b1, fire = 1'b0, gate_en = 1'b1;
    logic signed [15:0] amp;
    logic conn, mk;
    int n_fail = 0, total_checks = 0, cyc = 0, n;

    always #5 clk_i = ~clk_i;

    stes_top #(.KEY_HOLD_CYC(20)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .start_stimulus_input_i(trig), .gate_i(gate),
        .general_screen_key_i(key), .amplitude_o(amp),
        .output_connected_o(conn), .timing_marker_out_a_o(mk));
    stes_src #(.PW(PW)) u_src (.clk_i(clk_i), .fire_i(fire),
        .gate_en_i(gate_en), .trig_o(trig), .gate_o(gate));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard: the whole run needs under five thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wb(input logic we, input logic [7:0] a,
        input logic [3:0] s, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 40);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 40) n_fail++;
    endtask

    task automatic cfg(input stes_bank_type v);
        for (int i = 0; i < 11; i++) wb(1'b1, 8'(i * 4), 4'hf, v[i]);
    endtask

    // n counts edges until the marker shows level v, capped at lim
    task automatic wait_mk(input logic v, input int lim);
        n = 0;
        while (mk !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic shoot();
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    task automatic t_preset();
        repeat (40) @(posedge clk_i);
        key <= 1'b0;
        wb(1'b0, 8'h2c, 4'hf, '0);
        `CHK("preset flag", 1'b1, rd[4])
        wb(1'b0, 8'h10, 4'hf, '0);
        `CHK("preset trains", DEF_VAL[4], rd)
        wb(1'b0, 8'h08, 4'hf, '0);
        `CHK("preset window", DEF_VAL[2], rd)
        `CHK("preset connect", 1'b1, conn)
    endtask

    task automatic t_regs();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            wb(1'b0, 8'(i * 4), 4'hf, '0);
            `CHK("reset value", RST_VAL[i], rd)
        end
        wb(1'b1, 8'h04, 4'h1, 32'hffff_ffff);
        wb(1'b0, 8'h04, 4'hf, '0);
        `CHK("byte lane write", 32'h0000_00ff, rd)
        wb(1'b1, 8'h40, 4'hf, 32'h1234_5678);
        wb(1'b0, 8'h40, 4'hf, '0);
        `CHK("unmapped read", 32'h0, rd)
    endtask

    task automatic t_train();
        cfg('{32'h0, 300, 50, 120, 2, 0, 10, 20, 1, 0, 0});
        shoot();
        wait_mk(1'b1, 400);
        `CHK("train delay", 1'b1, n >= 300 && n <= 315)
        wait_mk(1'b0, 200);
        `CHK("window length", 50, n)
        wait_mk(1'b1, 200);
        `CHK("train period", 70, n)
        wait_mk(1'b0, 200);
        `CHK("second window", 50, n)
        wait_mk(1'b1, 400);
        `CHK("train count", 400, n)
        wb(1'b0, 8'h2c, 4'hf, '0);
        `CHK("busy after trains", 1'b0, rd[0])
        wb(1'b1, 8'h04, 4'hf, 32'h5);
        shoot();
        wait_mk(1'b1, 400);
        `CHK("minimum onset", 1'b1, n >= 200 && n <= 215)
        wait_mk(1'b0, 100);
        // two trains were asked for: let the second one finish too
        wait_mk(1'b1, 200);
        `CHK("short delay period", 70, n)
        wait_mk(1'b0, 100);
        `CHK("short delay window", 50, n)
    endtask

    task automatic t_event();
        cfg('{32'h10, 200, 200, 300, 1, 7, 5, 12, 3, 32'h10, 32'h100});
        shoot();
        wait_mk(1'b1, 400);
        `CHK("event onset", 1'b1, n >= 208 && n <= 225)
        for (int j = 0; j < 3; j++) begin
            `CHK("event level", 16'sh0110, amp)
            wait_mk(1'b0, 50);
            `CHK("event width", 5, n)
            `CHK("between events", 16'sh0010, amp)
            if (j < 2) begin
                wait_mk(1'b1, 50);
                `CHK("event gap", 7, n)
            end
        end
        wait_mk(1'b1, 300);
        `CHK("event quantity", 300, n)
        `CHK("idle level", 16'sh0000, amp)
    endtask

    task automatic t_trail();
        cfg('{32'h2, 200, 30, 60, 1, 0, 10, 20, 1, 0, 0});
        shoot();
        repeat (60) @(posedge clk_i);
        shoot();
        wait_mk(1'b1, 400);
        n = n + 62;
        `CHK("trail edge", 1'b1, n >= PW+200 && n <= PW+216)
        wait_mk(1'b0, 100);
        `CHK("trail window", 30, n)
        wait_mk(1'b1, 500);
        `CHK("busy trigger", 500, n)
    endtask

    task automatic t_gate();
        cfg('{32'h14, 200, 100, 200, 1, 0, 40, 60, 1, 32'hfff0, 32'h200});
        gate_en <= 1'b0;
        repeat (10) @(posedge clk_i);
        shoot();
        wait_mk(1'b1, 400);
        `CHK("gated trigger", 400, n)
        `CHK("gated level", 16'shfff0, amp)
        gate_en <= 1'b1;
        repeat (10) @(posedge clk_i);
        shoot();
        wait_mk(1'b1, 400);
        `CHK("hold event level", 16'sh0200, amp)
        repeat (10) @(posedge clk_i);
        gate_en <= 1'b0;
        wait_mk(1'b0, 12);
        `CHK("gate abort", 1'b1, n < 12)
        `CHK("abort level", 16'shfff0, amp)
        wb(1'b0, 8'h2c, 4'hf, '0);
        `CHK("busy after abort", 1'b0, rd[0])
        gate_en <= 1'b1;
    endtask

    task automatic t_free();
        cfg('{32'h9, 200, 20, 40, 1, 0, 10, 20, 1, 0, 0});
        wait_mk(1'b1, 260);
        `CHK("free run", 1'b1, n < 260)
        `CHK("connected", 1'b1, conn)
        wb(1'b1, 8'h00, 4'hf, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("disconnected", 1'b0, conn)
        wait_mk(1'b0, 40);
        wait_mk(1'b1, 300);
        `CHK("timing runs on", 1'b1, n < 300)
        wb(1'b1, 8'h00, 4'hf, 32'h0);
        repeat (400) @(posedge clk_i);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_preset();
        t_regs();
        repeat (6) @(posedge clk_i);
        t_train();
        t_event();
        t_trail();
        t_gate();
        t_free();
        wrap_up();
    end
endmodule // stes_top_bench
`default_nettype wire
